// ==== hdl/gcsdp_regs.v ====
// General control, status and software-definable pin registers
//
// Behaviour
// (RULE1) Control register answers identically at both of its two offsets.
// (RULE2) Master disable set blocks every new master request, manageability too.
// (RULE3) Master enable status reads 0 only when disabled and nothing pending.
// (RULE4) Link reset bit resets MAC, PCS, negotiation and core; self-clears.
// (RULE5) Device reset bit performs full reset, self-clears when done.
// (RULE6) Software resets restore core state, leave host configuration alone.
// (RULE7) Software waits about 1 ms after device reset before any access.
// (RULE8) Status shows two-bit port identifier: 00 first port, 01 second.
// (RULE9) Software writes reserved control bits zero; reserved bits read zero.
// (RULE10) No-snoop disable set suppresses no-snoop attribute on every packet.
// (RULE11) Relaxed-order disable set suppresses relaxed ordering requests.
// (RULE12) Driver sets loaded flag after load, clears on unload; BMC reads it.
// (RULE13) Output-configured pins 0..5 drive their data bit value.
// (RULE14) Input-configured pins 0..5 read back the sampled pin level.
// (RULE15) Direction bits 8..13 select pins 0..5: 0 input, 1 output.
// (RULE16) Direction bits survive software resets; power-on or write only.
// (RULE17) Pin 6 has separate sampled bit and driven bit.
// (RULE18) Pin 7 has separate sampled bit and writable driven bit.
// (RULE19) Pins 0..3 data and direction initial values load from EEPROM.
// (RULE20) Clearing master disable resumes requests and sets status to 1.
`include "gcsdp_map.vh"
`timescale 1ns/1ps
`default_nettype none

module gcsdp_regs #(
  parameter [`GC_CNT_W-1:0] RST_CYCLES = `GC_RST_CYCLES
) (
  input wire sys_clk,
  input wire arst_n,
  input wire reg_wr_en,
  input wire reg_rd_en,
  input wire [`GC_ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata,
  output reg reg_rd_valid,
  input wire [1:0] port_identifier,
  input wire mst_req_in,
  input wire mst_pending,
  output wire mst_req_out,
  input wire ns_attr_req,
  output wire ns_attr_out,
  input wire ro_cmd_en,
  input wire ro_attr_req,
  output wire ro_attr_out,
  output wire driver_loaded_flag,
  output wire link_rst_out,
  output wire core_rst_out,
  input wire eep_load,
  input wire [3:0] eep_pin_data,
  input wire [3:0] eep_pin_dir,
  input wire [5:0] software_pin_in,
  output wire [5:0] software_pin_out,
  output wire [5:0] software_pin_oe,
  input wire pin6_in,
  output wire pin6_out,
  output wire pin6_oe,
  input wire pin7_in,
  output wire pin7_out,
  output wire pin7_oe
);

  // ******************************************************************
  // Address decode
  // ******************************************************************
  // Unmapped offsets select nothing: writes vanish, reads give zero
  function [2:0] gc_sel;
    input [`GC_ADDR_W-1:0] addr;
    begin
      case (addr)
        `GC_OFF_CTRL: gc_sel = `GC_SEL_CTRL; // [RULE1]
        `GC_OFF_CTRL_ALIAS: gc_sel = `GC_SEL_CTRL; // [RULE1]
        `GC_OFF_STATUS: gc_sel = `GC_SEL_STATUS;
        `GC_OFF_EXT_CTRL: gc_sel = `GC_SEL_EXT_CTRL;
        `GC_OFF_PIN_CTRL: gc_sel = `GC_SEL_PIN_CTRL;
        `GC_OFF_OD_PIN: gc_sel = `GC_SEL_OD_PIN;
        default: gc_sel = `GC_SEL_NONE;
      endcase
    end
  endfunction

  // ******************************************************************
  // State
  // ******************************************************************
  reg mst_dis_r;
  reg mst_en_r;
  reg link_busy_r;
  reg dev_busy_r;
  reg [`GC_CNT_W-1:0] rst_cnt_r;
  reg no_snoop_disable_r;
  reg relaxed_order_disable_r;
  reg driver_loaded_flag_r;
  reg [5:0] pin_data_r;
  reg [5:0] pin_dir_r;
  // Last EEPROM image, reapplied to pins 0..3 by software resets
  reg [3:0] eep_data_r;
  reg pin6_drv_r;
  reg pin7_drv_r;
  localparam [`GC_CNT_W-1:0] CNT_ZERO = {`GC_CNT_W{1'b0}};

  wire [2:0] wr_sel;
  wire [2:0] rd_sel;
  wire busy;
  wire wr_ok;
  wire wr_ctrl;
  wire start_link;
  wire start_dev;
  wire sw_rst;
  wire wr_ext;
  wire wr_pin;
  wire wr_od;
  wire [5:0] pin_rd;

  // One decode for both directions keeps the alias in a single place
  assign wr_sel = gc_sel(reg_addr);
  assign rd_sel = gc_sel(reg_addr);
  assign busy = link_busy_r | dev_busy_r;
  // Writes during a reset run are dropped; software must not issue them
  assign wr_ok = reg_wr_en & ~busy; // [RULE7]
  assign wr_ctrl = wr_ok & (wr_sel == `GC_SEL_CTRL);
  assign start_link = wr_ctrl & reg_wdata[`GC_CTRL_LINK_RST];
  assign start_dev = wr_ctrl & reg_wdata[`GC_CTRL_DEV_RST];
  assign sw_rst = start_link | start_dev;
  assign wr_ext = wr_ok & (wr_sel == `GC_SEL_EXT_CTRL);
  assign wr_pin = wr_ok & (wr_sel == `GC_SEL_PIN_CTRL);
  assign wr_od = wr_ok & (wr_sel == `GC_SEL_OD_PIN);

  // ******************************************************************
  // Software reset sequencer
  // ******************************************************************
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      link_busy_r <= 1'b0;
      dev_busy_r <= 1'b0;
      rst_cnt_r <= CNT_ZERO;
    end else if (sw_rst) begin
      link_busy_r <= start_link; // [RULE4]
      dev_busy_r <= start_dev; // [RULE5]
      // Busy drops writes, so a start always finds the counter idle
      rst_cnt_r <= RST_CYCLES - 1'b1;
    end else if (busy) begin
      if (rst_cnt_r == CNT_ZERO) begin
        link_busy_r <= 1'b0; // [RULE4]
        dev_busy_r <= 1'b0; // [RULE5]
      end else begin
        rst_cnt_r <= rst_cnt_r - 1'b1;
      end
    end
  end

  // Device reset covers the link too; host config is not in this block
  assign link_rst_out = busy; // [RULE4] [RULE5]
  assign core_rst_out = busy; // [RULE6]

  // ******************************************************************
  // Master request gating
  // ******************************************************************
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mst_dis_r <= `GC_RST_MST_DIS;
      mst_en_r <= `GC_RST_MST_EN;
    end else begin
      if (sw_rst) begin
        mst_dis_r <= `GC_RST_MST_DIS; // [RULE6]
      end else if (wr_ctrl) begin
        mst_dis_r <= reg_wdata[`GC_CTRL_MST_DIS]; // [RULE20]
      end
      // Drops only once disabled and the pending count has drained
      mst_en_r <= ~(mst_dis_r & ~mst_pending); // [RULE3] [RULE20]
    end
  end

  // Gated at the source, so no request slips out after the write lands
  assign mst_req_out = mst_req_in & ~mst_dis_r; // [RULE2]

  // ******************************************************************
  // Extended control and attribute gating
  // ******************************************************************
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      no_snoop_disable_r <= `GC_RST_NO_SNOOP_DISABLE;
      relaxed_order_disable_r <= `GC_RST_RELAXED_ORDER_DISABLE;
      driver_loaded_flag_r <= `GC_RST_DRIVER_LOADED_FLAG;
    end else if (sw_rst) begin
      no_snoop_disable_r <= `GC_RST_NO_SNOOP_DISABLE; // [RULE6]
      relaxed_order_disable_r <= `GC_RST_RELAXED_ORDER_DISABLE; // [RULE6]
      // Management must not trust a driver that did not see this reset
      driver_loaded_flag_r <= `GC_RST_DRIVER_LOADED_FLAG; // [RULE6]
    end else if (wr_ext) begin
      no_snoop_disable_r <= reg_wdata[`GC_EXT_NO_SNOOP_DISABLE];
      relaxed_order_disable_r <= reg_wdata[`GC_EXT_RELAXED_ORDER_DISABLE];
      driver_loaded_flag_r <= reg_wdata[`GC_EXT_DRIVER_LOADED_FLAG]; // [RULE12]
    end
  end

  assign ns_attr_out = ns_attr_req & ~no_snoop_disable_r; // [RULE10]
  assign ro_attr_out = ro_attr_req & ro_cmd_en & ~relaxed_order_disable_r; // [RULE11]
  assign driver_loaded_flag = driver_loaded_flag_r; // [RULE12]

  // ******************************************************************
  // Software-definable pins
  // ******************************************************************
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_data_r <= `GC_RST_PIN_DATA;
      pin_dir_r <= `GC_RST_PIN_DIR;
      eep_data_r <= `GC_RST_EEP_DATA;
      pin6_drv_r <= `GC_RST_OD_DRV;
      pin7_drv_r <= `GC_RST_OD_DRV;
    end else begin
      if (eep_load) begin
        // EEPROM image replaces the fixed constants for pins 0..3
        eep_data_r <= eep_pin_data; // [RULE19]
        pin_data_r[3:0] <= eep_pin_data; // [RULE19]
        pin_dir_r[3:0] <= eep_pin_dir; // [RULE19]
      end else if (sw_rst) begin
        // Direction deliberately kept across software resets
        pin_data_r <= {2'h0, eep_data_r}; // [RULE6] [RULE16]
        // Open-drain pads driven low again, as after power-on
        pin6_drv_r <= `GC_RST_OD_DRV;
        pin7_drv_r <= `GC_RST_OD_DRV;
      end else begin
        if (wr_pin) begin
          pin_data_r <= reg_wdata[`GC_PIN_DATA_LO +: 6]; // [RULE13]
          pin_dir_r <= reg_wdata[`GC_PIN_DIR_LO +: 6]; // [RULE15]
        end
        if (wr_od) begin
          pin6_drv_r <= reg_wdata[`GC_OD_PIN6_DRV]; // [RULE17]
          pin7_drv_r <= reg_wdata[`GC_OD_PIN7_DRV]; // [RULE18]
        end
      end
    end
  end

  assign software_pin_out = pin_data_r; // [RULE13]
  assign software_pin_oe = pin_dir_r; // [RULE15]
  assign pin_rd = (pin_dir_r & pin_data_r) |
                  (~pin_dir_r & software_pin_in); // [RULE14]

  // ******************************************************************
  // Open-drain pads: only the low level is ever driven
  // ******************************************************************
  assign pin6_out = 1'b0;
  assign pin6_oe = ~pin6_drv_r; // [RULE17]
  assign pin7_out = 1'b0;
  assign pin7_oe = ~pin7_drv_r; // [RULE18]

  // ******************************************************************
  // Read path
  // ******************************************************************
  // Reads stay legal during a reset run; busy bits show its progress
  reg [31:0] rd_nxt;

  always @* begin
    rd_nxt = 32'h00000000; // [RULE9]
    case (rd_sel)
      `GC_SEL_CTRL: begin
        rd_nxt[`GC_CTRL_MST_DIS] = mst_dis_r;
        rd_nxt[`GC_CTRL_LINK_RST] = link_busy_r; // [RULE4]
        rd_nxt[`GC_CTRL_DEV_RST] = dev_busy_r; // [RULE5]
      end
      `GC_SEL_STATUS: begin
        rd_nxt[`GC_STAT_PORT_ID_LO +: 2] = port_identifier; // [RULE8]
        rd_nxt[`GC_STAT_MST_EN] = mst_en_r; // [RULE3]
      end
      `GC_SEL_EXT_CTRL: begin
        rd_nxt[`GC_EXT_NO_SNOOP_DISABLE] = no_snoop_disable_r;
        rd_nxt[`GC_EXT_RELAXED_ORDER_DISABLE] = relaxed_order_disable_r;
        rd_nxt[`GC_EXT_DRIVER_LOADED_FLAG] = driver_loaded_flag_r;
      end
      `GC_SEL_PIN_CTRL: begin
        rd_nxt[`GC_PIN_DATA_LO +: 6] = pin_rd; // [RULE14]
        rd_nxt[`GC_PIN_DIR_LO +: 6] = pin_dir_r;
      end
      `GC_SEL_OD_PIN: begin
        rd_nxt[`GC_OD_PIN6_IN] = pin6_in; // [RULE17]
        rd_nxt[`GC_OD_PIN6_DRV] = pin6_drv_r;
        rd_nxt[`GC_OD_PIN7_IN] = pin7_in; // [RULE18]
        rd_nxt[`GC_OD_PIN7_DRV] = pin7_drv_r;
      end
      default: rd_nxt = 32'h00000000;
    endcase
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h00000000;
      reg_rd_valid <= 1'b0;
    end else begin
      // Data holds until the next read, so a slow master may sample late
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rdata <= rd_nxt;
      end
    end
  end

endmodule

`default_nettype wire

// ==== inc/gcsdp_map.vh ====
// Register map, field positions and timing counts of the control block
`ifndef GCSDP_MAP_VH
`define GCSDP_MAP_VH

// ********************************************************************
// Register offsets (byte addresses)
// ********************************************************************
`define GC_ADDR_W 17
`define GC_OFF_CTRL 17'h00000
`define GC_OFF_CTRL_ALIAS 17'h00004
`define GC_OFF_STATUS 17'h00008
`define GC_OFF_EXT_CTRL 17'h00018
`define GC_OFF_PIN_CTRL 17'h00020
`define GC_OFF_OD_PIN 17'h00028

// ********************************************************************
// Register selects
// ********************************************************************
`define GC_SEL_NONE 3'h0
`define GC_SEL_CTRL 3'h1
`define GC_SEL_STATUS 3'h2
`define GC_SEL_EXT_CTRL 3'h3
`define GC_SEL_PIN_CTRL 3'h4
`define GC_SEL_OD_PIN 3'h5

// ********************************************************************
// Field positions
// ********************************************************************
`define GC_CTRL_MST_DIS 2
`define GC_CTRL_LINK_RST 3
`define GC_CTRL_DEV_RST 26
`define GC_STAT_PORT_ID_LO 2
`define GC_STAT_MST_EN 19
`define GC_EXT_NO_SNOOP_DISABLE 16
`define GC_EXT_RELAXED_ORDER_DISABLE 17
`define GC_EXT_DRIVER_LOADED_FLAG 28
`define GC_PIN_DATA_LO 0
`define GC_PIN_DIR_LO 8
`define GC_OD_PIN6_IN 0
`define GC_OD_PIN6_DRV 1
`define GC_OD_PIN7_IN 2
`define GC_OD_PIN7_DRV 3

// ********************************************************************
// Reset values
// ********************************************************************
`define GC_RST_MST_DIS 1'h0
`define GC_RST_MST_EN 1'h1
`define GC_RST_NO_SNOOP_DISABLE 1'h0
`define GC_RST_RELAXED_ORDER_DISABLE 1'h0
`define GC_RST_DRIVER_LOADED_FLAG 1'h0
`define GC_RST_PIN_DATA 6'h00
`define GC_RST_PIN_DIR 6'h00
`define GC_RST_OD_DRV 1'h0
`define GC_RST_EEP_DATA 4'h0

// ********************************************************************
// Timing
// ********************************************************************
`define GC_CLK_MHZ 200
`define GC_RST_WAIT_MS 1
// One millisecond of the core clock, sized to the counter
`define GC_RST_CYCLES 18'h30D40
`define GC_CNT_W 18

`endif

// ==== verif/gcsdp_board.sv ====
// Board circuitry model on the software pins
`timescale 1ns/1ps
`default_nettype none
module gcsdp_board (
  input wire [5:0] software_pin_out,
  input wire [5:0] software_pin_oe,
  input wire pin6_out,
  input wire pin6_oe,
  input wire pin7_out,
  input wire pin7_oe,
  input wire [7:0] board_lvl,
  output wire [5:0] software_pin_in,
  output wire pin6_in,
  output wire pin7_in
);
  // Board releases a pin the block drives
  assign software_pin_in = (software_pin_oe & software_pin_out) |
    (~software_pin_oe & board_lvl[5:0]);
  // Pulled-up pads: low when either side sinks
  assign pin6_in = board_lvl[6] & ~(pin6_oe & ~pin6_out);
  assign pin7_in = board_lvl[7] & ~(pin7_oe & ~pin7_out);
endmodule
`default_nettype wire

// ==== verif/gcsdp_regs_checker.sv ====
// Port-level checker of the control register block
`timescale 1ns/1ps
`default_nettype none
`include "gcsdp_map.vh"
module gcsdp_regs_checker #(
  parameter int RST_CYCLES = 8
) (
  input wire sys_clk,
  input wire arst_n,
  input wire reg_wr_en,
  input wire [`GC_ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire mst_req_in,
  input wire mst_req_out,
  input wire ns_attr_req,
  input wire ns_attr_out,
  input wire ro_cmd_en,
  input wire ro_attr_req,
  input wire ro_attr_out,
  input wire link_rst_out,
  input wire core_rst_out,
  input wire eep_load,
  input wire [5:0] software_pin_oe,
  input wire pin6_out,
  input wire pin7_out,
  input wire pin6_oe,
  input wire pin7_oe
);
  logic ctrl_wr;
  logic ext_wr;
  logic od_wr;
  logic no_snoop_disable_m;
  logic relaxed_order_disable_m;
  logic dir_why_r;
  int span_r;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  // Writes during a running reset are dropped, so they start nothing
  assign ctrl_wr = reg_wr_en && !link_rst_out &&
    (reg_addr == `GC_OFF_CTRL || reg_addr == `GC_OFF_CTRL_ALIAS);
  assign ext_wr = reg_wr_en && !link_rst_out &&
    reg_addr == `GC_OFF_EXT_CTRL;
  assign od_wr = reg_wr_en && !link_rst_out && reg_addr == `GC_OFF_OD_PIN;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dir_why_r <= 1'b0;
      span_r <= 0;
      no_snoop_disable_m <= 1'b0;
      relaxed_order_disable_m <= 1'b0;
    end else begin
      dir_why_r <= eep_load || (reg_wr_en && reg_addr == `GC_OFF_PIN_CTRL);
      span_r <= link_rst_out ? span_r + 1 : 0;
      if (ctrl_wr && (reg_wdata[3] || reg_wdata[26])) begin
        no_snoop_disable_m <= 1'b0;
        relaxed_order_disable_m <= 1'b0;
      end else if (ext_wr) begin
        no_snoop_disable_m <= reg_wdata[16];
        relaxed_order_disable_m <= reg_wdata[17];
      end
    end
  end
  AST_REQ_BLOCK: assert property (ctrl_wr && reg_wdata[2] &&
    !reg_wdata[3] && !reg_wdata[26] |=> !mst_req_out [*3])
    else $error("request passed while disabled");
  AST_REQ_RESUME: assert property (ctrl_wr && !reg_wdata[2] |=>
    mst_req_out == mst_req_in) else $error("request not resumed");
  AST_NS_BLOCK: assert property (ns_attr_out ==
    (ns_attr_req && !no_snoop_disable_m)) else $error("no-snoop attribute wrong");
  AST_RO_BLOCK: assert property (ro_attr_out ==
    (ro_attr_req && ro_cmd_en && !relaxed_order_disable_m))
    else $error("relaxed order attribute wrong");
  AST_LINK_GO: assert property (ctrl_wr && reg_wdata[3] |=>
    link_rst_out) else $error("link reset did not start");
  AST_DEV_GO: assert property (ctrl_wr && reg_wdata[26] |=>
    core_rst_out && link_rst_out) else $error("device reset did not start");
  AST_RST_SPAN: assert property ($fell(link_rst_out) |->
    span_r == RST_CYCLES) else $error("reset span has wrong length");
  AST_DIR_HOLD: assert property (!$stable(software_pin_oe) |->
    dir_why_r) else $error("direction changed without a cause");
  AST_OD_LOW: assert property (!pin6_out && !pin7_out)
    else $error("open-drain pad driven high");
  AST_OD_DRIVE: assert property (od_wr |=>
    pin6_oe == !$past(reg_wdata[1]) && pin7_oe == !$past(reg_wdata[3]))
    else $error("open-drain drive bit not applied");
endmodule
bind gcsdp_regs gcsdp_regs_checker #(.RST_CYCLES(RST_CYCLES)) u_chk (
  .sys_clk(sys_clk), .arst_n(arst_n), .reg_wr_en(reg_wr_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .mst_req_in(mst_req_in),
  .mst_req_out(mst_req_out), .ns_attr_req(ns_attr_req),
  .ns_attr_out(ns_attr_out), .ro_cmd_en(ro_cmd_en),
  .ro_attr_req(ro_attr_req), .ro_attr_out(ro_attr_out),
  .link_rst_out(link_rst_out), .core_rst_out(core_rst_out),
  .eep_load(eep_load), .software_pin_oe(software_pin_oe),
  .pin6_out(pin6_out), .pin7_out(pin7_out), .pin6_oe(pin6_oe),
  .pin7_oe(pin7_oe));
`default_nettype wire

// ==== verif/gcsdp_regs_tb_top.sv ====
// Self-checking bench of the control register block
`timescale 1ns/1ps
`default_nettype none
`include "gcsdp_map.vh"
module gcsdp_regs_tb_top;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [16:0] reg_addr = 17'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [1:0] port_identifier = 2'h1;
  logic mst_req_in = 1'b1;
  logic mst_pending = 1'b1;
  logic ns_attr_req = 1'b0;
  logic ro_cmd_en = 1'b0;
  logic ro_attr_req = 1'b0;
  logic eep_load = 1'b0;
  logic [3:0] eep_pin_data = 4'h0;
  logic [3:0] eep_pin_dir = 4'h0;
  logic [7:0] board_lvl = 8'hFF;
  logic [31:0] seed = 32'h62A4A403;
  logic [31:0] r;
  logic [31:0] exp_q[$];
  logic [5:0] dir_m = 6'h0;
  logic [5:0] dat_m = 6'h0;
  int failures = 0;
  int check_count = 0;
  int n;
  wire [31:0] reg_rdata;
  wire reg_rd_valid, mst_req_out, ns_attr_out, ro_attr_out;
  wire driver_loaded_flag, link_rst_out, core_rst_out;
  wire pin6_in, pin6_out, pin6_oe, pin7_in, pin7_out, pin7_oe;
  wire [5:0] software_pin_in, software_pin_out, software_pin_oe;
  gcsdp_regs #(.RST_CYCLES(18'h8)) dut (.sys_clk(sys_clk), .arst_n(arst_n),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .port_identifier(port_identifier),
    .mst_req_in(mst_req_in), .mst_pending(mst_pending),
    .mst_req_out(mst_req_out), .ns_attr_req(ns_attr_req),
    .ns_attr_out(ns_attr_out), .ro_cmd_en(ro_cmd_en),
    .ro_attr_req(ro_attr_req), .ro_attr_out(ro_attr_out),
    .driver_loaded_flag(driver_loaded_flag), .link_rst_out(link_rst_out),
    .core_rst_out(core_rst_out), .eep_load(eep_load),
    .eep_pin_data(eep_pin_data), .eep_pin_dir(eep_pin_dir),
    .software_pin_in(software_pin_in), .software_pin_out(software_pin_out),
    .software_pin_oe(software_pin_oe), .pin6_in(pin6_in),
    .pin6_out(pin6_out), .pin6_oe(pin6_oe), .pin7_in(pin7_in),
    .pin7_out(pin7_out), .pin7_oe(pin7_oe));
  gcsdp_board board (.software_pin_out(software_pin_out),
    .software_pin_oe(software_pin_oe), .pin6_out(pin6_out),
    .pin6_oe(pin6_oe), .pin7_out(pin7_out), .pin7_oe(pin7_oe),
    .board_lvl(board_lvl), .software_pin_in(software_pin_in),
    .pin6_in(pin6_in), .pin7_in(pin7_in));
  always #2.5 sys_clk = ~sys_clk;
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] st(input logic b);
    return {12'h0, b, 15'h0, port_identifier, 2'h0};
  endfunction
  function automatic logic [31:0] pins();
    return {18'h0, dir_m, 2'h0, dir_m & dat_m | ~dir_m & board_lvl[5:0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [16:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [16:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge sys_clk);
    reg_rd_en <= 1'b0;
  endtask
  always @(negedge sys_clk) begin
    if (reg_rd_valid === 1'b1) begin
      if (exp_q.size() == 0)
        chk("spare read", 32'h1, 32'h0);
      else
        chk("rdata", reg_rdata, exp_q.pop_front());
    end
  end
  initial begin
    #200000;
    failures++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(`GC_OFF_STATUS, st(1'b1));
    rd(17'h00010, 32'h0);
    wr(`GC_OFF_CTRL_ALIAS, 32'h4);
    rd(`GC_OFF_CTRL, 32'h4);
    rd(`GC_OFF_STATUS, st(1'b1));
    mst_pending <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rd(`GC_OFF_STATUS, st(1'b0));
    wr(`GC_OFF_CTRL, 32'h0);
    rd(`GC_OFF_STATUS, st(1'b1));
    for (int i = 0; i < 6; i++) begin
      r = xs();
      wr(`GC_OFF_EXT_CTRL, r & 32'h1003_0000);
      ns_attr_req <= r[0];
      ro_attr_req <= r[1];
      ro_cmd_en <= r[2];
      mst_req_in <= r[3];
      rd(`GC_OFF_EXT_CTRL, r & 32'h1003_0000);
      @(negedge sys_clk);
      chk("ns", ns_attr_out, r[0] & ~r[16]);
      chk("ro", ro_attr_out, r[1] & r[2] & ~r[17]);
      chk("drv", driver_loaded_flag, r[28]);
      chk("req", mst_req_out, r[3]);
    end
    for (int i = 0; i < 6; i++) begin
      r = xs();
      dir_m = r[13:8];
      dat_m = r[5:0];
      wr(`GC_OFF_PIN_CTRL, {18'h0, dir_m, 2'h0, dat_m});
      board_lvl <= r[31:24];
      wr(`GC_OFF_OD_PIN, {28'h0, r[3], 1'b0, r[1], 1'b0});
      repeat (3) @(posedge sys_clk);
      rd(`GC_OFF_PIN_CTRL, pins());
      rd(`GC_OFF_OD_PIN, {28'h0, r[3], r[3] & r[31], r[1],
        r[1] & r[30]});
      chk("pin out", software_pin_out & dir_m, dat_m & dir_m);
      chk("pin dir", software_pin_oe, dir_m);
      chk("od oe", {pin7_oe, pin6_oe}, {~r[3], ~r[1]});
    end
    r = xs();
    @(posedge sys_clk);
    eep_pin_data <= r[3:0];
    eep_pin_dir <= r[7:4];
    eep_load <= 1'b1;
    @(posedge sys_clk);
    eep_load <= 1'b0;
    dat_m[3:0] = r[3:0];
    dir_m[3:0] = r[7:4];
    repeat (3) @(posedge sys_clk);
    rd(`GC_OFF_PIN_CTRL, pins());
    for (int k = 0; k < 2; k++) begin
      r = k ? 32'h0400_0000 : 32'h0000_0008;
      wr(`GC_OFF_EXT_CTRL, 32'h1003_0000);
      wr(`GC_OFF_CTRL, r);
      // Dropped: a reset is running
      wr(`GC_OFF_PIN_CTRL, 32'h0);
      rd(`GC_OFF_CTRL, r);
      chk("core rst", core_rst_out, 32'h1);
      for (n = 0; n < 50 && link_rst_out !== 1'b0; n++)
        @(posedge sys_clk);
      if (n == 50) begin
        failures++;
        wrap_up();
      end
      dat_m[5:4] = 2'h0;
      repeat (3) @(posedge sys_clk);
      chk("core idle", core_rst_out, 32'h0);
      rd(`GC_OFF_CTRL, 32'h0);
      rd(`GC_OFF_EXT_CTRL, 32'h0);
      rd(`GC_OFF_PIN_CTRL, pins());
      rd(`GC_OFF_OD_PIN, 32'h0);
    end
    repeat (4) @(posedge sys_clk);
    chk("queue", exp_q.size(), 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
